// File: drf_pkg.sv
// Purpose: shared constants and helpers for the dual bank register file
// Assumes: two clusters of four units, slots L, S, M, D in that order
// Notes: units 0-3 belong to cluster one, units 4-7 to cluster two
package drf_pkg;
    localparam int DRF_REGS = 16;
    localparam int DRF_AW = 4;
    localparam int DRF_DW = 32;
    localparam int DRF_LW = 8;
    localparam int DRF_UNITS = 8;
    localparam int DRF_PER_CL = 4;
    localparam int DRF_LONG_UNITS = 4;
    localparam int DRF_PKT_W = 256;
    localparam int DRF_INSTR_N = 8;
    localparam int DRF_INSTR_W = 32;
    localparam int DRF_PTR_W = 3;
    localparam int DRF_LINK_BIT = 0;
    localparam int DRF_SOFF_W = 5;
    localparam int DRF_LOFF_W = 15;
    localparam int DRF_CSIZE_W = 5;
    localparam int DRF_CIRC_N = 4;
    localparam int DRF_S2 = 5;
    localparam int DRF_D1 = 3;
    localparam int DRF_D2 = 7;
    localparam logic [15:0] DRF_COND_A = 16'h0006;
    localparam logic [15:0] DRF_COND_B = 16'h0007;
    localparam logic [3:0] DRF_CIRC_LO = 4'h4;
    localparam logic [3:0] DRF_CIRC_HI = 4'h7;
    localparam logic [DRF_PTR_W-1:0] DRF_LAST = 3'h7;

    typedef enum logic {DRF_IDLE, DRF_ISSUE} drf_disp_t;

    // Odd partner of an even register
    function automatic logic [DRF_AW-1:0] drf_pair_hi(input logic [DRF_AW-1:0] a);
        drf_pair_hi = {a[DRF_AW-1:1], 1'b1};
    endfunction : drf_pair_hi

    // Register may guard an instruction
    function automatic logic drf_cond_ok(input logic bank, input logic [DRF_AW-1:0] a);
        drf_cond_ok = bank ? DRF_COND_B[a] : DRF_COND_A[a];
    endfunction : drf_cond_ok

    // Register may use circular addressing
    function automatic logic drf_circ_ok(input logic [DRF_AW-1:0] a);
        drf_circ_ok = (a >= DRF_CIRC_LO) && (a <= DRF_CIRC_HI);
    endfunction : drf_circ_ok

    // Unit number of long port l (L1, S1, L2, S2)
    function automatic int drf_long_unit(input int l);
        drf_long_unit = (l / 2) * DRF_PER_CL + (l % 2);
    endfunction : drf_long_unit
endpackage : drf_pkg

// File: drf_reg_banks.sv
// Purpose: two 16 x 32 register banks with unit ports, fetch packet split
// Assumes: inputs synchronous to i_clock; units drive flat packed port groups
// Notes: reads are registered, a read sees the bank before same-edge writes
// Notes on behaviour
// - Two banks A and B, sixteen 32-bit registers each.
// - Only A1, A2, B0, B1, B2 may act as condition registers.
// - Only registers 4 to 7 of each bank may address circularly.
// - 40-bit value: low word in even register, top byte in odd.
// - 64-bit doubles use the same even/odd pairing.
// - Cluster one writes only bank A, cluster two only bank B.
// - Every unit has its own 32-bit write port; all eight write together.
// - Every unit has two 32-bit read ports, first and second operand.
// - L and S units add 8-bit long write port and long read input.
// - One shared cross-bank bus per cluster, one access per cycle.
// - Control register transfers go only through cluster-two shift unit.
// - Only the two address units move data between banks and memory.
// - 5-bit offsets on both address units, 15-bit only on cluster two.
// - Address units add, subtract, and form linear or circular addresses.
// - Fetch takes one 256-bit packet of eight instructions, at most one every two cycles.
// - Linked instructions issue together, at most eight per execute packet.
// - No dependency checking or interlock; the stream schedules operands.
// - Logic-arithmetic units get 32/40-bit operands for arithmetic and counts.
// - Shift units get 32/40-bit operands for shifts and field work.
`timescale 1ns/1ps
module drf_reg_banks
    import drf_pkg::*;
#(
    parameter int NUM_REGS = DRF_REGS,
    parameter int DATA_W = DRF_DW
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Unit write ports
    input wire logic [DRF_UNITS-1:0] i_wr_en,
    input wire logic [DRF_UNITS*DRF_AW-1:0] i_wr_addr,
    input wire logic [DRF_UNITS*DRF_DW-1:0] i_wr_data,
    // Long write ports, L1 S1 L2 S2
    input wire logic [DRF_LONG_UNITS-1:0] i_lwr_en,
    input wire logic [DRF_LONG_UNITS*DRF_LW-1:0] i_lwr_data,
    // Unit read ports
    input wire logic [DRF_UNITS*DRF_AW-1:0] i_rd_addr1,
    input wire logic [DRF_UNITS*DRF_AW-1:0] i_rd_addr2,
    input wire logic [DRF_UNITS-1:0] i_x1,
    input wire logic [DRF_UNITS-1:0] i_x2,
    output logic [DRF_UNITS*DRF_DW-1:0] o_first_operand,
    output logic [DRF_UNITS*DRF_DW-1:0] o_second_operand,
    output logic [DRF_LONG_UNITS*DRF_LW-1:0] o_long_operand,
    output logic [1:0] o_cross_clash,
    // Condition reads
    input wire logic [DRF_UNITS-1:0] i_cond_use,
    input wire logic [DRF_UNITS-1:0] i_cond_bank,
    input wire logic [DRF_UNITS*DRF_AW-1:0] i_cond_addr,
    output logic [DRF_UNITS-1:0] o_cond_true,
    output logic [DRF_UNITS-1:0] o_cond_illegal,
    // Address units and addressing mode
    input wire logic [1:0] i_d_go,
    input wire logic [1:0] i_d_sub,
    input wire logic [1:0] i_d_long,
    input wire logic [2*DRF_LOFF_W-1:0] i_d_offset,
    input wire logic [2*DRF_CIRC_N-1:0] i_circ_mode,
    input wire logic [2*DRF_CSIZE_W-1:0] i_circ_size,
    output logic [DRF_DW-1:0] o_addr_path_a,
    output logic [DRF_DW-1:0] o_addr_path_b,
    output logic [1:0] o_addr_valid,
    output logic [1:0] o_d_refused,
    // Load and store paths
    input wire logic [1:0] i_load_en,
    input wire logic [2*DRF_AW-1:0] i_load_addr,
    input wire logic [2*DRF_DW-1:0] i_load_data,
    input wire logic [1:0] i_store_en,
    input wire logic [2*DRF_AW-1:0] i_store_addr,
    output logic [DRF_DW-1:0] o_store_path_a,
    output logic [DRF_DW-1:0] o_store_path_b,
    output logic [1:0] o_store_valid,
    // Control register transfers
    input wire logic i_ctl_from,
    input wire logic [DRF_DW-1:0] i_ctl_rd_data,
    input wire logic i_ctl_to,
    output logic o_ctl_wr_en,
    output logic [DRF_DW-1:0] o_ctl_wr_data,
    // Fetch and execute packets
    input wire logic i_fetch_valid,
    input wire logic [DRF_PKT_W-1:0] i_fetch_packet,
    output logic o_fetch_ready,
    output logic o_exec_valid,
    output logic [DRF_PKT_W-1:0] o_exec_packet,
    output logic [DRF_INSTR_N-1:0] o_exec_mask
);
    if (NUM_REGS != (1 << DRF_AW) || DATA_W != DRF_DW) begin : g_bad_size
        $error("drf_reg_banks: bank size or width not supported");
    end

    // Two banks, index 0 is A, 1 is B
    logic [DRF_DW-1:0] bank [2][DRF_REGS];
    logic [1:0] cross_valid;
    logic [DRF_AW-1:0] cross_addr [2];
    logic [1:0] next_clash;
    logic [DRF_DW-1:0] cross_data [2];
    drf_disp_t state;
    logic [DRF_PKT_W-1:0] pkt;
    logic [DRF_PTR_W-1:0] ptr;
    logic [DRF_PTR_W-1:0] exec_end;
    logic [DRF_INSTR_N-1:0] next_mask;

    // Bank writes; unit u lands in bank u/4 only
    always_ff @(posedge i_clock) begin
        for (int u = 0; u < DRF_UNITS; u++) begin
            if (i_wr_en[u]) begin
                bank[u / DRF_PER_CL][i_wr_addr[u*DRF_AW +: DRF_AW]] <=
                    (u == DRF_S2 && i_ctl_from) ? i_ctl_rd_data : i_wr_data[u*DRF_DW +: DRF_DW];
            end
        end
        // Long byte goes to odd partner of an even write address
        for (int l = 0; l < DRF_LONG_UNITS; l++) begin
            if (i_lwr_en[l] && !i_wr_addr[drf_long_unit(l)*DRF_AW]) begin
                bank[l / 2][drf_pair_hi(i_wr_addr[drf_long_unit(l)*DRF_AW +: DRF_AW])] <=
                    {{(DRF_DW-DRF_LW){1'b0}}, i_lwr_data[l*DRF_LW +: DRF_LW]};
            end
        end
        // Memory loads arrive only on the address unit paths
        for (int b = 0; b < 2; b++) begin
            if (i_load_en[b]) begin
                bank[b][i_load_addr[b*DRF_AW +: DRF_AW]] <= i_load_data[b*DRF_DW +: DRF_DW];
            end
        end
    end

    // One cross bus per cluster; first requester sets its address
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            cross_valid[c] = 1'b0;
            cross_addr[c] = '0;
            next_clash[c] = 1'b0;
            for (int s = 0; s < DRF_PER_CL; s++) begin
                for (int op = 0; op < 2; op++) begin
                    if (op == 0 ? i_x1[c*DRF_PER_CL+s] : i_x2[c*DRF_PER_CL+s]) begin
                        if (!cross_valid[c]) begin
                            cross_valid[c] = 1'b1;
                            cross_addr[c] = op == 0 ? i_rd_addr1[(c*DRF_PER_CL+s)*DRF_AW +: DRF_AW]
                                                    : i_rd_addr2[(c*DRF_PER_CL+s)*DRF_AW +: DRF_AW];
                        end else if (cross_addr[c] != (op == 0 ? i_rd_addr1[(c*DRF_PER_CL+s)*DRF_AW +: DRF_AW]
                                                               : i_rd_addr2[(c*DRF_PER_CL+s)*DRF_AW +: DRF_AW])) begin
                            next_clash[c] = 1'b1;
                        end
                    end
                end
            end
            cross_data[c] = bank[1-c][cross_addr[c]];
        end
    end

    // Operand reads; no hazard check, old value seen on a write edge
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_first_operand <= '0;
            o_second_operand <= '0;
            o_long_operand <= '0;
            o_cross_clash <= '0;
        end else begin
            for (int u = 0; u < DRF_UNITS; u++) begin
                o_first_operand[u*DRF_DW +: DRF_DW] <= i_x1[u] ? cross_data[u / DRF_PER_CL]
                    : bank[u / DRF_PER_CL][i_rd_addr1[u*DRF_AW +: DRF_AW]];
                o_second_operand[u*DRF_DW +: DRF_DW] <= i_x2[u] ? cross_data[u / DRF_PER_CL]
                    : bank[u / DRF_PER_CL][i_rd_addr2[u*DRF_AW +: DRF_AW]];
            end
            // Top byte of the pair named by the second operand
            for (int l = 0; l < DRF_LONG_UNITS; l++) begin
                o_long_operand[l*DRF_LW +: DRF_LW] <=
                    bank[l / 2][drf_pair_hi(i_rd_addr2[drf_long_unit(l)*DRF_AW +: DRF_AW])][DRF_LW-1:0];
            end
            o_cross_clash <= next_clash;
        end
    end

    // Condition reads, refused outside the allowed set
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_cond_true <= '0;
            o_cond_illegal <= '0;
        end else begin
            for (int u = 0; u < DRF_UNITS; u++) begin
                o_cond_illegal[u] <= i_cond_use[u]
                    && !drf_cond_ok(i_cond_bank[u], i_cond_addr[u*DRF_AW +: DRF_AW]);
                o_cond_true[u] <= i_cond_use[u] && drf_cond_ok(i_cond_bank[u], i_cond_addr[u*DRF_AW +: DRF_AW])
                    && (bank[i_cond_bank[u]][i_cond_addr[u*DRF_AW +: DRF_AW]] != '0);
            end
        end
    end

    // Address units: base from first operand register, offset, wrap
    always_ff @(posedge i_clock) begin
        logic [DRF_AW-1:0] rb;
        logic [DRF_DW-1:0] base;
        logic [DRF_DW-1:0] off;
        logic [DRF_DW-1:0] sum;
        logic [DRF_DW-1:0] wrap;
        rb = '0;
        base = '0;
        off = '0;
        sum = '0;
        wrap = '0;
        if (!i_rst_n) begin
            o_addr_path_a <= '0;
            o_addr_path_b <= '0;
            o_addr_valid <= '0;
            o_d_refused <= '0;
        end else begin
            for (int d = 0; d < 2; d++) begin
                rb = i_rd_addr1[(d == 0 ? DRF_D1 : DRF_D2)*DRF_AW +: DRF_AW];
                base = bank[d][rb];
                off = i_d_long[d] ? {{(DRF_DW-DRF_LOFF_W){1'b0}}, i_d_offset[d*DRF_LOFF_W +: DRF_LOFF_W]}
                    : {{(DRF_DW-DRF_SOFF_W){1'b0}}, i_d_offset[d*DRF_LOFF_W +: DRF_SOFF_W]};
                sum = i_d_sub[d] ? base - off : base + off;
                wrap = (32'h0000_0002 << i_circ_size[d*DRF_CSIZE_W +: DRF_CSIZE_W]) - 32'h0000_0001;
                if (drf_circ_ok(rb) && i_circ_mode[d*DRF_CIRC_N + 32'(rb - DRF_CIRC_LO)]) begin
                    sum = (base & ~wrap) | (sum & wrap);
                end
                o_d_refused[d] <= i_d_go[d] && i_d_long[d] && d == 0;
                o_addr_valid[d] <= i_d_go[d] && !(i_d_long[d] && d == 0);
                if (i_d_go[d] && !(i_d_long[d] && d == 0)) begin
                    if (d == 0) begin
                        o_addr_path_a <= sum;
                    end else begin
                        o_addr_path_b <= sum;
                    end
                end
            end
        end
    end

    // Store data leaves only through the two address unit paths
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_store_path_a <= '0;
            o_store_path_b <= '0;
            o_store_valid <= '0;
        end else begin
            o_store_valid <= i_store_en;
            if (i_store_en[0]) begin
                o_store_path_a <= bank[0][i_store_addr[0 +: DRF_AW]];
            end
            if (i_store_en[1]) begin
                o_store_path_b <= bank[1][i_store_addr[DRF_AW +: DRF_AW]];
            end
        end
    end

    // Cluster-two shift unit first operand feeds the control bank
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_ctl_wr_en <= 1'b0;
            o_ctl_wr_data <= '0;
        end else begin
            o_ctl_wr_en <= i_ctl_to;
            o_ctl_wr_data <= bank[1][i_rd_addr1[DRF_S2*DRF_AW +: DRF_AW]];
        end
    end

    // End of execute packet: first unlinked slot from ptr
    always_comb begin
        exec_end = DRF_LAST;
        next_mask = '0;
        for (int i = DRF_INSTR_N - 1; i >= 0; i--) begin
            if (i >= int'(ptr) && !pkt[i*DRF_INSTR_W + DRF_LINK_BIT]) begin
                exec_end = DRF_PTR_W'(i);
            end
        end
        for (int i = 0; i < DRF_INSTR_N; i++) begin
            next_mask[i] = (i >= int'(ptr)) && (i <= int'(exec_end));
        end
    end

    // Fetch packet dispatch into execute packets
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state <= DRF_IDLE;
            pkt <= '0;
            ptr <= '0;
            o_fetch_ready <= 1'b1;
            o_exec_valid <= 1'b0;
            o_exec_packet <= '0;
            o_exec_mask <= '0;
        end else begin
            o_exec_valid <= 1'b0;
            case (state)
                DRF_IDLE: begin
                    if (i_fetch_valid) begin
                        pkt <= i_fetch_packet;
                        ptr <= '0;
                        o_fetch_ready <= 1'b0;
                        state <= DRF_ISSUE;
                    end
                end
                DRF_ISSUE: begin
                    o_exec_valid <= 1'b1;
                    o_exec_packet <= pkt;
                    o_exec_mask <= next_mask;
                    if (exec_end == DRF_LAST) begin
                        o_fetch_ready <= 1'b1;
                        state <= DRF_IDLE;
                    end else begin
                        ptr <= exec_end + 3'h1;
                    end
                end
                default: begin
                    state <= DRF_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    property p_write_read;
        (i_wr_en[0] && i_wr_en[3:1] == 3'h0 && !i_load_en[0] && i_lwr_en[1:0] == 2'h0)
        ##1 (i_rd_addr1[3:0] == $past(i_wr_addr[3:0]) && !i_x1[0])
        |=> o_first_operand[31:0] == $past(i_wr_data[31:0], 2);
    endproperty
    a_write_read: assert property (p_write_read) else $error("written word not read back");
    property p_cond_illegal;
        i_cond_use[0] && !i_cond_bank[0] && i_cond_addr[3:0] == 4'h3 |=> o_cond_illegal[0] && !o_cond_true[0];
    endproperty
    a_cond_illegal: assert property (p_cond_illegal) else $error("A3 accepted as condition");
    property p_cross_clash;
        i_x1[0] && i_x1[1] && i_rd_addr1[3:0] != i_rd_addr1[7:4] |=> o_cross_clash[0];
    endproperty
    a_cross_clash: assert property (p_cross_clash) else $error("second cross access not flagged");
    property p_d1_long;
        i_d_go[0] && i_d_long[0] |=> o_d_refused[0] && !o_addr_valid[0];
    endproperty
    a_d1_long: assert property (p_d1_long) else $error("long offset taken on cluster one");
    property p_d2_long;
        i_d_go[1] && i_d_long[1] |=> o_addr_valid[1] && !o_d_refused[1];
    endproperty
    a_d2_long: assert property (p_d2_long) else $error("long offset refused on cluster two");
    property p_mask;
        o_exec_valid |-> o_exec_mask != 8'h00 && o_exec_mask[7] == o_fetch_ready
            && $onehot(9'(o_exec_mask) + 9'(o_exec_mask & (~o_exec_mask + 8'h01)));
    endproperty
    a_mask: assert property (p_mask) else $error("execute packet mask broken");
    property p_fetch_walk;
        o_fetch_ready && i_fetch_valid |=> !o_fetch_ready ##1 o_exec_valid;
    endproperty
    a_fetch_walk: assert property (p_fetch_walk) else $error("fetch packet not dispatched");
    property p_ctl;
        i_ctl_to ##1 !i_ctl_to |-> o_ctl_wr_en ##1 !o_ctl_wr_en;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control transfer strobe wrong");
    c_full_packet: cover property (o_exec_valid && o_exec_mask == 8'hFF);
    c_cross: cover property (i_x1[4] ##1 !o_cross_clash[1]);
    c_refuse: cover property (o_d_refused[0]);
    c_cond: cover property (o_cond_true[7]);
endmodule : drf_reg_banks

// File: drf_ctl_model.sv
// Purpose: control register bank seen by the cluster-two shift unit
// Assumes: one control word, written on the pulse, read back at any time
// Notes: start value is arbitrary; only the S2 transfer ports reach it
`timescale 1ns/1ps
module drf_ctl_model #(
    parameter logic [31:0] START = 32'h5A5A_0F0F
) (
    // Clock
    input wire logic i_clock,
    // Transfer from the banks
    input wire logic i_ctl_wr_en,
    input wire logic [31:0] i_ctl_wr_data,
    // Transfer to the banks
    output logic [31:0] o_ctl_rd_data
);
    logic [31:0] word = START;

    // Capture the moved word on the write pulse
    always_ff @(posedge i_clock) begin
        if (i_ctl_wr_en) begin
            word <= i_ctl_wr_data;
        end
    end

    // Word is always readable by the shift unit
    assign o_ctl_rd_data = word;
endmodule : drf_ctl_model

// File: dual_bank_register_file_ports_tb_top.sv
// Purpose: self-checking bench for the dual bank register file
// Assumes: inputs change on the falling edge, outputs checked a cycle later
// Notes: a shadow of both banks gives every expected operand
`timescale 1ns/1ps
module dual_bank_register_file_ports_tb_top;
    import drf_pkg::*;
    logic i_clock = 1'b0, i_rst_n, i_ctl_from, i_ctl_to, i_fetch_valid;
    logic [7:0] i_wr_en, i_x1, i_x2, i_cond_use, i_cond_bank, i_circ_mode, i_load_addr, i_store_addr;
    logic [31:0] i_wr_addr, i_rd_addr1, i_rd_addr2, i_cond_addr, i_lwr_data, i_ctl_rd_data;
    logic [255:0] i_wr_data, i_fetch_packet, o_first_operand, o_second_operand, o_exec_packet, pkt;
    logic [3:0] i_lwr_en;
    logic [1:0] i_d_go, i_d_sub, i_d_long, i_load_en, i_store_en, o_cross_clash, o_addr_valid, o_d_refused, o_store_valid;
    logic [29:0] i_d_offset;
    logic [9:0] i_circ_size;
    logic [63:0] i_load_data;
    logic [31:0] o_long_operand, o_addr_path_a, o_addr_path_b, o_store_path_a, o_store_path_b, o_ctl_wr_data, d;
    logic [7:0] o_cond_true, o_cond_illegal, o_exec_mask, m, b0, b1;
    logic o_ctl_wr_en, o_fetch_ready, o_exec_valid, lg;
    logic [31:0] bank [2][16];
    logic [31:0] e1 [8], e2 [8];
    logic [14:0] off;
    int bad_count = 0, n_checks = 0, s;

    drf_reg_banks DUT (.i_clock, .i_rst_n, .i_wr_en, .i_wr_addr, .i_wr_data, .i_lwr_en, .i_lwr_data,
        .i_rd_addr1, .i_rd_addr2, .i_x1, .i_x2, .o_first_operand, .o_second_operand, .o_long_operand,
        .o_cross_clash, .i_cond_use, .i_cond_bank, .i_cond_addr, .o_cond_true, .o_cond_illegal, .i_d_go,
        .i_d_sub, .i_d_long, .i_d_offset, .i_circ_mode, .i_circ_size, .o_addr_path_a, .o_addr_path_b,
        .o_addr_valid, .o_d_refused, .i_load_en, .i_load_addr, .i_load_data, .i_store_en, .i_store_addr,
        .o_store_path_a, .o_store_path_b, .o_store_valid, .i_ctl_from, .i_ctl_rd_data, .i_ctl_to,
        .o_ctl_wr_en, .o_ctl_wr_data, .i_fetch_valid, .i_fetch_packet, .o_fetch_ready, .o_exec_valid,
        .o_exec_packet, .o_exec_mask);
    drf_ctl_model PARTNER (.i_clock, .i_ctl_wr_en(o_ctl_wr_en), .i_ctl_wr_data(o_ctl_wr_data),
        .o_ctl_rd_data(i_ctl_rd_data));

    // Free-running 50 MHz clock
    always #10 i_clock = ~i_clock;

    task automatic print_verdict;
        if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tick;
        @(negedge i_clock);
    endtask : tick

    task automatic idle;
        {i_wr_en, i_lwr_en, i_x1, i_x2, i_cond_use, i_d_go, i_load_en, i_store_en} = '0;
        {i_ctl_from, i_ctl_to, i_fetch_valid} = '0;
    endtask : idle

    // Unit write, mirrored into the shadow banks
    task automatic wr(input int u, input logic [3:0] a, input logic [31:0] dv);
        i_wr_en[u] = 1'b1;
        i_wr_addr[4*u+:4] = a;
        i_wr_data[32*u+:32] = dv;
        bank[u/4][a] = dv;
    endtask : wr

    // Address unit request; base is the first operand of D1 or D2
    task automatic dgo(input int i, input logic sb, input logic lo, input logic [3:0] r, input logic [14:0] o);
        i_d_go[i] = 1'b1;
        i_d_sub[i] = sb;
        i_d_long[i] = lo;
        i_d_offset[15*i+:15] = o;
        i_rd_addr1[4*(3+4*i)+:4] = r;
    endtask : dgo

    function automatic logic [31:0] dexp(input logic [31:0] b, input logic [14:0] o, input logic sb,
        input logic circ, input logic [4:0] sz);
        logic [31:0] sm, mk;
        sm = sb ? b - {17'h0, o} : b + {17'h0, o};
        mk = (32'h2 << sz) - 32'h1;
        dexp = circ ? ((b & ~mk) | (sm & mk)) : sm;
    endfunction : dexp

    function automatic logic [7:0] gmask(input logic [255:0] p, input int st);
        gmask = '0;
        for (int i = st; i < 8; i++) begin
            gmask[i] = 1'b1;
            if (p[32*i] == 1'b0) break;
        end
    endfunction : gmask

    // Watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge i_clock);
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        void'($urandom(32'hEB86D8D4));
        idle();
        {i_rst_n, i_wr_addr, i_wr_data, i_rd_addr1, i_rd_addr2, i_cond_bank, i_cond_addr, i_lwr_data} = '0;
        {i_d_sub, i_d_long, i_d_offset, i_circ_mode, i_circ_size, i_load_addr, i_load_data} = '0;
        {i_store_addr, i_fetch_packet} = '0;
        repeat (5) tick();
        chk("fetch_ready", 1'b1, o_fetch_ready);
        chk("exec_valid", 1'b0, o_exec_valid);
        i_rst_n = 1'b1;
        // Fill both banks, all eight units writing each cycle
        for (int r = 0; r < 4; r++) begin
            for (int u = 0; u < 8; u++) wr(u, 4'(4 * r + u % 4), $urandom);
            tick();
        end
        idle();
        // Random reads with one write on the same edge
        for (int k = 0; k < 24; k++) begin
            for (int u = 0; u < 8; u++) begin
                i_rd_addr1[4*u+:4] = 4'($urandom);
                i_rd_addr2[4*u+:4] = 4'($urandom);
                e1[u] = bank[u/4][i_rd_addr1[4*u+:4]];
                e2[u] = bank[u/4][i_rd_addr2[4*u+:4]];
            end
            wr($urandom % 8, 4'($urandom), $urandom);
            tick();
            idle();
            for (int u = 0; u < 8; u++) begin
                chk("first_operand", e1[u], o_first_operand[32*u+:32]);
                chk("second_operand", e2[u], o_second_operand[32*u+:32]);
            end
        end
        // Long writes and long reads, L1 and S2
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        wr(0, 4'h6, $urandom);
        wr(5, 4'h8, $urandom);
        {i_lwr_en, i_lwr_data} = {4'h9, b1, 16'h0, b0};
        bank[0][7] = {24'h0, b0};
        bank[1][9] = {24'h0, b1};
        tick();
        idle();
        i_rd_addr2[3:0] = 4'h6;
        i_rd_addr2[23:20] = 4'h8;
        tick();
        chk("long_l1", b0, o_long_operand[7:0]);
        chk("long_s2", b1, o_long_operand[31:24]);
        chk("low_word", bank[0][6], o_second_operand[31:0]);
        // Cross bus, plain then two distinct requests in each cluster
        for (int c = 0; c < 2; c++) begin
            i_x1[4] = 1'b1;
            i_rd_addr1[19:16] = 4'h3;
            i_x2[6] = c[0];
            i_rd_addr2[27:24] = 4'h5;
            i_x2[1] = 1'b1;
            i_rd_addr2[7:4] = 4'h9;
            i_x1[1:0] = {c[0], c[0]};
            i_rd_addr1[7:0] = 8'h29;
            tick();
            chk("cross_a", bank[0][3], o_first_operand[159:128]);
            chk("cross_b", bank[1][9], o_second_operand[63:32]);
            chk("cross_clash", {c[0], c[0]}, o_cross_clash);
            if (c == 1) chk("cross_shared", bank[0][3], o_second_operand[223:192]);
        end
        idle();
        // Condition registers over both banks, rotating the unit
        wr(4, 4'h1, 32'h0);
        wr(0, 4'h2, 32'h0);
        i_rd_addr1[3:0] = 4'h2;
        tick();
        idle();
        for (int r = 0; r < 32; r++) begin
            s = r % 8;
            i_cond_use[s] = 1'b1;
            i_cond_bank[s] = r[4];
            i_cond_addr[4*s+:4] = r[3:0];
            lg = r[4] ? (r[3:0] <= 2) : (r[3:0] == 1 || r[3:0] == 2);
            tick();
            idle();
            chk("cond_illegal", !lg, o_cond_illegal[s]);
            chk("cond_true", lg && bank[r/16][r%16] != 0, o_cond_true[s]);
        end
        // Address units: long offset, refusal, subtract, circular
        i_circ_mode = 8'h10;
        i_circ_size = 10'h060;
        off = 15'($urandom);
        dgo(1, 1'b0, 1'b1, 4'h3, off);
        tick();
        idle();
        chk("addr_b", dexp(bank[1][3], off, 1'b0, 1'b0, 5'h0), o_addr_path_b);
        chk("addr_valid", 2'b10, o_addr_valid);
        dgo(0, 1'b0, 1'b1, 4'h5, off);
        tick();
        idle();
        chk("d_refused", 2'b01, o_d_refused);
        chk("addr_a_hold", 32'h0, o_addr_path_a);
        dgo(0, 1'b1, 1'b0, 4'h5, off);
        tick();
        idle();
        chk("addr_a_sub", dexp(bank[0][5], {10'h0, off[4:0]}, 1'b1, 1'b0, 5'h0), o_addr_path_a);
        dgo(0, 1'b0, 1'b0, 4'h4, off);
        dgo(1, 1'b0, 1'b0, 4'h4, off);
        tick();
        idle();
        chk("addr_a_lin", dexp(bank[0][4], {10'h0, off[4:0]}, 1'b0, 1'b0, 5'h0), o_addr_path_a);
        chk("addr_b_circ", dexp(bank[1][4], {10'h0, off[4:0]}, 1'b0, 1'b1, 5'h3), o_addr_path_b);
        chk("addr_valid", 2'b11, o_addr_valid);
        // Load into bank A while storing from bank B, then store the loaded word
        d = $urandom;
        {i_load_en, i_load_addr, i_load_data} = {2'b01, 8'h0A, 32'h0, d};
        {i_store_en, i_store_addr} = {2'b10, 8'h20};
        tick();
        idle();
        bank[0][10] = d;
        chk("store_b", bank[1][2], o_store_path_b);
        chk("store_valid", 2'b10, o_store_valid);
        {i_store_en, i_store_addr} = {2'b01, 8'h0A};
        tick();
        idle();
        chk("store_a", d, o_store_path_a);
        // Control transfers through the cluster-two shift unit
        i_ctl_to = 1'b1;
        i_rd_addr1[23:20] = 4'h7;
        tick();
        idle();
        chk("ctl_wr_en", 1'b1, o_ctl_wr_en);
        chk("ctl_wr_data", bank[1][7], o_ctl_wr_data);
        tick();
        chk("ctl_pulse", 1'b0, o_ctl_wr_en);
        i_ctl_from = 1'b1;
        wr(5, 4'hC, ~bank[1][7]);
        bank[1][12] = bank[1][7];
        tick();
        idle();
        i_rd_addr1[23:20] = 4'hC;
        tick();
        chk("ctl_read", bank[1][12], o_first_operand[191:160]);
        // Fetch packets: all linked, none linked, then random
        for (int k = 0; k < 5; k++) begin
            for (int i = 0; i < 8; i++) pkt[32*i+:32] = $urandom;
            for (int i = 0; i < 8; i++) if (k < 2) pkt[32*i] = (k == 0);
            i_fetch_valid = 1'b1;
            i_fetch_packet = pkt;
            tick();
            idle();
            chk("fetch_busy", 1'b0, o_fetch_ready);
            chk("exec_early", 1'b0, o_exec_valid);
            s = 0;
            while (s < 8) begin
                tick();
                m = gmask(pkt, s);
                s += $countones(m);
                chk("exec_valid", 1'b1, o_exec_valid);
                chk("exec_mask", m, o_exec_mask);
                chk("exec_packet", pkt, o_exec_packet);
                chk("fetch_ready", s == 8, o_fetch_ready);
            end
        end
        print_verdict();
    end
endmodule : dual_bank_register_file_ports_tb_top
